// ---- adc_core_model.sv ----
// Purpose: Behavioural converter core that answers each start pulse.
// Assumes: One conversion at a time with a fixed latency.
// Notes:   An abort or a fresh start drops the conversion in flight.
`timescale 1ns/1ps
module adc_core_model #(
	parameter int LAT = 8 // Cycles from start to done.
) (
	input  wire logic clk_i,   // System clock.
	input  wire logic rst_i,   // Sync reset, high.
	input  wire logic start_i, // Start pulse.
	input  wire logic abort_i, // Abort pulse.
	output logic      done_o   // Finished pulse.
);
	int cnt; // Cycles left, zero when idle.
	// ==========================================================
	// Count down, so an aborted channel never reports done.
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i)
			cnt <= 0;
		else if (start_i)
			cnt <= LAT; // A restart pairs abort with a fresh start.
		else if (abort_i)
			cnt <= 0;
		else if (cnt > 0) begin
			cnt <= cnt - 1;
			done_o <= (cnt == 1);
		end
	end
endmodule : adc_core_model

// ---- adc_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the converter control block.
// Assumes: Registers are 8 bits wide and sit in the low byte of a word.
// Notes:   Bit k of a printed byte field Dn maps to bit (7 - n mod 8).
package adc_ctrl_pkg;

	// ==========================================================
	// Register byte addresses.
	localparam logic [31:0] SCAN_CONTROL_ADDR          = 32'h0080_0084;
	localparam logic [31:0] SINGLE_CHANNEL_CONFIG_ADDR = 32'h0080_0090;
	localparam logic [31:0] SCAN_CHANNEL_CONFIG_ADDR   = 32'h0080_0094;
	localparam logic [31:0] SINGLE_COMMAND_ADDR        = 32'h0080_0098;

	// ==========================================================
	// Field positions in scan_control.
	localparam int SC_TYPE_BIT  = 6; // Scan type, one-shot or continuous.
	localparam int SC_HWSEL_BIT = 5; // Hardware trigger source.
	localparam int SC_KIND_BIT  = 4; // Software or hardware trigger.
	localparam int SC_REQ_BIT   = 3; // Interrupt or DMA request.
	localparam int SC_DONE_BIT  = 2; // Scan completion flag.
	localparam int SC_STOP_BIT  = 1; // Scan stop command.
	localparam int SC_START_BIT = 0; // Scan start command.

	// Field positions in single_channel_config.
	localparam int SCC_FUNC_BIT = 7; // Conversion or comparator.
	localparam int SCC_RATE_BIT = 6; // Normal or double rate.
	localparam int SCC_CH_LSB   = 0; // Input select, four bits.

	// Field positions in scan_channel_config and single_command.
	localparam int SCH_RATE_BIT   = 6; // Scan conversion rate.
	localparam int SCH_LOOP_LSB   = 2; // Scan loop field, two bits.
	localparam int SCH_CH_LSB     = 0; // Channel status on read.
	localparam int SCMD_START_BIT = 0; // Single start command.

	// ==========================================================
	// Reset values.
	localparam logic [7:0] SCAN_CONTROL_RESET          = 8'h04;
	localparam logic [7:0] SINGLE_CHANNEL_CONFIG_RESET = 8'h00;
	localparam logic [7:0] SCAN_CHANNEL_CONFIG_RESET   = 8'h00;

	// ==========================================================
	// Scan loop codes and channel limits.
	localparam logic [1:0] LOOP_4CH   = 2'h1;
	localparam logic [1:0] LOOP_8CH   = 2'h2;
	localparam logic [3:0] FIRST_CH   = 4'h0;
	localparam logic [3:0] LAST_4CH   = 4'h3;
	localparam logic [3:0] LAST_8CH   = 4'h7;
	localparam logic [3:0] LAST_16CH  = 4'hf;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Types.
	typedef logic [3:0] channel_t;
	typedef enum logic [1:0] {st_idle, st_single, st_scan} seq_state_t;

endpackage : adc_ctrl_pkg

// ---- adc_scan_ctrl.sv ----
// Purpose: Single and scan mode control of a sixteen input converter.
// Assumes: The core pulses conv_done_i once per started conversion.
// Notes:   Registers are reached over AXI4-Lite, low byte lane only.
//
// Behaviour
// - Function bit picks conversion or comparator.
// - Rate bit picks normal or double speed.
// - Four-bit field selects one of sixteen inputs.
// - Channel field reads back the current scan channel.
// - Type bit picks one-shot or continuous scan.
// - One-shot scan stops after last channel.
// - Continuous scan wraps until stop command.
// - Hardware trigger uses timer event bus three.
// - Trigger kind picks software or hardware start.
// - Pass end raises interrupt or DMA request.
// - Done flag resets one, zero while scanning.
// - Stop halts at once, result discarded.
// - Scan stop leaves single conversion running.
// - Start plus stop together counts as stop.
// - Start bit works only with software trigger.
// - Start during scan restarts from beginning.
// - Start during single queues scan afterwards.
// - Single start interrupts scan, then resumes.
// - Scan loop field sets the channel range.
`timescale 1ns/1ps
module adc_scan_ctrl #(
	parameter int ADDR_W = 32 // AXI address width.
) (
	input  wire logic              clk_i,            // System clock.
	input  wire logic              rst_i,            // Sync reset, high.
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,   // Write address.
	input  wire logic              s_axi_awvalid_i,  // Write addr valid.
	output logic                   s_axi_awready_o,  // Write addr ready.
	input  wire logic [31:0]       s_axi_wdata_i,    // Write data.
	input  wire logic [3:0]        s_axi_wstrb_i,    // Write strobes.
	input  wire logic              s_axi_wvalid_i,   // Write data valid.
	output logic                   s_axi_wready_o,   // Write data ready.
	output logic [1:0]             s_axi_bresp_o,    // Write response.
	output logic                   s_axi_bvalid_o,   // Response valid.
	input  wire logic              s_axi_bready_i,   // Response ready.
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,   // Read address.
	input  wire logic              s_axi_arvalid_i,  // Read addr valid.
	output logic                   s_axi_arready_o,  // Read addr ready.
	output logic [31:0]            s_axi_rdata_o,    // Read data.
	output logic [1:0]             s_axi_rresp_o,    // Read response.
	output logic                   s_axi_rvalid_o,   // Read data valid.
	input  wire logic              s_axi_rready_i,   // Read data ready.
	input  wire logic              hw_trigger_i,     // Timer event pulse.
	input  wire logic              conv_done_i,      // Core finished.
	output logic                   conv_start_o,     // Start pulse.
	output logic                   conv_abort_o,     // Abort pulse.
	output adc_ctrl_pkg::channel_t conv_channel_o,   // Input to convert.
	output logic                   conv_compare_o,   // Comparator mode.
	output logic                   conv_double_o,    // Double rate.
	output logic                   result_store_o,   // Keep result pulse.
	output adc_ctrl_pkg::channel_t result_channel_o, // Result's channel.
	output logic                   pass_irq_o,       // Interrupt pulse.
	output logic                   pass_dma_o        // DMA request pulse.
);
	import adc_ctrl_pkg::*;

	// ==========================================================
	// Bus slave state.
	logic              aw_held;   // Write address captured.
	logic              w_held;    // Write data captured.
	logic [ADDR_W-1:0] aw_addr_q; // Captured write address.
	logic [7:0]        w_data_q;  // Captured low data byte.
	logic              w_lane_q;  // Low byte lane enabled.
	logic              wr_fire;   // Write is applied this cycle.
	logic              wr_ctrl;   // Write to scan_control.
	logic              wr_cmd;    // Write to single_command.

	// Register fields.
	logic     scan_type;   // Continuous when high.
	logic     scan_hwsel;  // Event bus three selected.
	logic     scan_kind;   // Hardware trigger when high.
	logic     scan_req;    // DMA request when high.
	logic     scan_done;   // Completion flag.
	logic     single_func; // Comparator when high.
	logic     single_rate; // Double rate when high.
	channel_t single_sel;  // Single mode input.
	logic     scan_rate;   // Scan double rate.
	logic [1:0] scan_loop; // Scan loop field.

	// Sequencer state and decisions.
	seq_state_t state;         // Sequencer state.
	seq_state_t next_state;    // Its next value.
	logic       queued;        // Scan waits for single to end.
	logic       next_queued;   // Its next value.
	channel_t   resume_ch;     // Where the waiting scan begins.
	channel_t   next_resume;   // Its next value.
	logic       next_done;     // Next completion flag.
	channel_t   cur_ch;        // Channel of the scan in hand.
	channel_t   shown_ch;      // Channel shown on read.
	logic       start_cmd;     // Accepted software scan start.
	logic       stop_cmd;      // Scan stop command.
	logic       hw_start;      // Accepted hardware scan start.
	logic       scan_go;       // Any effective scan start.
	logic       single_go;     // Single start command.
	logic       launch_scan;   // Start a scan channel.
	channel_t   launch_ch;     // Channel for launch_scan.
	logic       launch_single; // Start a single conversion.
	logic       abort;         // Drop the conversion in hand.
	logic       store;         // Keep the finished result.
	channel_t   store_ch;      // Channel of the kept result.
	logic       pass_end;      // A scan pass has finished.

	scan_step_if sp (); // Link to the channel stepper.

	scan_step scan_step_i (
		.sp (sp.step)
	);

	assign sp.loop = scan_loop;
	assign sp.cur  = cur_ch;

	// ==========================================================
	// Write channel: address and data are taken in either order.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_awready_o <= 1'b0;
			aw_held         <= 1'b0;
			aw_addr_q       <= '0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			s_axi_awready_o <= 1'b0;
			aw_held         <= 1'b1;
			aw_addr_q       <= s_axi_awaddr_i;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end else if (!aw_held && !s_axi_bvalid_o) begin
			s_axi_awready_o <= 1'b1; // Reopen once the response is gone.
		end
	end

	// Write data capture mirrors the address side.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_wready_o <= 1'b0;
			w_held         <= 1'b0;
			w_data_q       <= 8'h00;
			w_lane_q       <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			s_axi_wready_o <= 1'b0;
			w_held         <= 1'b1;
			w_data_q       <= s_axi_wdata_i[7:0];
			w_lane_q       <= s_axi_wstrb_i[0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end else if (!w_held && !s_axi_bvalid_o) begin
			s_axi_wready_o <= 1'b1;
		end
	end

	assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_ctrl = wr_fire && w_lane_q
		&& (aw_addr_q == ADDR_W'(SCAN_CONTROL_ADDR));
	assign wr_cmd  = wr_fire && w_lane_q
		&& (aw_addr_q == ADDR_W'(SINGLE_COMMAND_ADDR));

	// Write response; unmapped addresses answer with a slave error.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			if (aw_addr_q == ADDR_W'(SCAN_CONTROL_ADDR)
				|| aw_addr_q == ADDR_W'(SINGLE_CHANNEL_CONFIG_ADDR)
				|| aw_addr_q == ADDR_W'(SCAN_CHANNEL_CONFIG_ADDR)
				|| aw_addr_q == ADDR_W'(SINGLE_COMMAND_ADDR)) begin
				s_axi_bresp_o <= RESP_OKAY;
			end else begin
				s_axi_bresp_o <= RESP_SLVERR;
			end
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration fields; command bits are never stored.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scan_type   <= SCAN_CONTROL_RESET[SC_TYPE_BIT];
			scan_hwsel  <= SCAN_CONTROL_RESET[SC_HWSEL_BIT];
			scan_kind   <= SCAN_CONTROL_RESET[SC_KIND_BIT];
			scan_req    <= SCAN_CONTROL_RESET[SC_REQ_BIT];
			single_func <= SINGLE_CHANNEL_CONFIG_RESET[SCC_FUNC_BIT];
			single_rate <= SINGLE_CHANNEL_CONFIG_RESET[SCC_RATE_BIT];
			single_sel  <= SINGLE_CHANNEL_CONFIG_RESET[SCC_CH_LSB +: 4];
			scan_rate   <= SCAN_CHANNEL_CONFIG_RESET[SCH_RATE_BIT];
			scan_loop   <= SCAN_CHANNEL_CONFIG_RESET[SCH_LOOP_LSB +: 2];
		end else if (wr_fire && w_lane_q) begin
			if (aw_addr_q == ADDR_W'(SCAN_CONTROL_ADDR)) begin
				scan_type  <= w_data_q[SC_TYPE_BIT];
				scan_hwsel <= w_data_q[SC_HWSEL_BIT];
				scan_kind  <= w_data_q[SC_KIND_BIT];
				scan_req   <= w_data_q[SC_REQ_BIT];
			end else if (aw_addr_q == ADDR_W'(SINGLE_CHANNEL_CONFIG_ADDR)) begin
				single_func <= w_data_q[SCC_FUNC_BIT];
				single_rate <= w_data_q[SCC_RATE_BIT];
				single_sel  <= w_data_q[SCC_CH_LSB +: 4];
			end else if (aw_addr_q == ADDR_W'(SCAN_CHANNEL_CONFIG_ADDR)) begin
				scan_rate <= w_data_q[SCH_RATE_BIT];
				scan_loop <= w_data_q[SCH_LOOP_LSB +: 2];
			end
		end
	end

	// ==========================================================
	// Read channel; one read is answered at a time.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= RESP_OKAY;
			s_axi_rdata_o   <= 32'h0000_0000; // Command bits read zero.
			if (s_axi_araddr_i == ADDR_W'(SCAN_CONTROL_ADDR)) begin
				s_axi_rdata_o[SC_TYPE_BIT]  <= scan_type;
				s_axi_rdata_o[SC_HWSEL_BIT] <= scan_hwsel;
				s_axi_rdata_o[SC_KIND_BIT]  <= scan_kind;
				s_axi_rdata_o[SC_REQ_BIT]   <= scan_req;
				s_axi_rdata_o[SC_DONE_BIT]  <= scan_done;
			end else if (s_axi_araddr_i == ADDR_W'(SINGLE_CHANNEL_CONFIG_ADDR)) begin
				s_axi_rdata_o[SCC_FUNC_BIT]    <= single_func;
				s_axi_rdata_o[SCC_RATE_BIT]    <= single_rate;
				s_axi_rdata_o[SCC_CH_LSB +: 4] <= single_sel;
			end else if (s_axi_araddr_i == ADDR_W'(SCAN_CHANNEL_CONFIG_ADDR)) begin
				s_axi_rdata_o[SCH_RATE_BIT]    <= scan_rate;
				s_axi_rdata_o[SCH_CH_LSB +: 4] <= shown_ch;
			end else if (s_axi_araddr_i != ADDR_W'(SINGLE_COMMAND_ADDR)) begin
				s_axi_rresp_o <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end else if (!s_axi_rvalid_o) begin
			s_axi_arready_o <= 1'b1;
		end
	end

	// ==========================================================
	// Commands. Stop beats start in the same write, and a start only
	// counts while the software trigger is chosen.
	assign stop_cmd  = wr_ctrl && w_data_q[SC_STOP_BIT];
	assign start_cmd = wr_ctrl && w_data_q[SC_START_BIT]
		&& !w_data_q[SC_STOP_BIT] && !scan_kind;
	assign hw_start  = scan_kind && scan_hwsel && hw_trigger_i;
	assign scan_go   = (start_cmd || hw_start) && !stop_cmd;
	assign single_go = wr_cmd && w_data_q[SCMD_START_BIT];

	// Sequencer decisions for this cycle.
	always_comb begin
		next_state    = state;
		next_queued   = queued;
		next_resume   = resume_ch;
		next_done     = scan_done;
		launch_scan   = 1'b0;
		launch_ch     = FIRST_CH;
		launch_single = 1'b0;
		abort         = 1'b0;
		store         = 1'b0;
		store_ch      = cur_ch;
		pass_end      = 1'b0;
		case (state)
			st_idle: begin
				if (single_go) begin
					launch_single = 1'b1;
					next_state    = st_single;
				end else if (scan_go) begin
					launch_scan = 1'b1;
					next_done   = 1'b0;
					next_state  = st_scan;
				end
			end
			st_single: begin
				// A waiting scan can be cancelled, the single runs on.
				if (stop_cmd) begin
					next_queued = 1'b0;
					next_done   = 1'b1;
				end else if (scan_go) begin
					next_queued = 1'b1;
					next_resume = FIRST_CH;
					next_done   = 1'b0;
				end
				if (single_go) begin
					abort         = 1'b1;
					launch_single = 1'b1;
				end else if (conv_done_i) begin
					store    = !conv_compare_o;
					store_ch = conv_channel_o;
					if (next_queued) begin
						launch_scan = 1'b1;
						launch_ch   = next_resume;
						next_queued = 1'b0;
						next_state  = st_scan;
					end else begin
						next_state = st_idle;
					end
				end
			end
			default: begin
				if (stop_cmd) begin
					abort      = 1'b1;
					next_done  = 1'b1;
					next_state = st_idle;
				end else if (single_go) begin
					abort         = 1'b1;
					launch_single = 1'b1;
					next_queued   = 1'b1;
					next_resume   = cur_ch;
					next_state    = st_single;
				end else if (scan_go) begin
					abort       = 1'b1;
					launch_scan = 1'b1;
				end else if (conv_done_i) begin
					store = 1'b1;
					if (sp.last) begin
						pass_end = 1'b1;
						if (scan_type) begin
							launch_scan = 1'b1;
						end else begin
							next_done  = 1'b1;
							next_state = st_idle;
						end
					end else begin
						launch_scan = 1'b1;
						launch_ch   = sp.next;
					end
				end
			end
		endcase
	end

	// Sequencer state and completion flag.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= st_idle;
			queued    <= 1'b0;
			resume_ch <= FIRST_CH;
			scan_done <= SCAN_CONTROL_RESET[SC_DONE_BIT];
		end else begin
			state     <= next_state;
			queued    <= next_queued;
			resume_ch <= next_resume;
			scan_done <= next_done;
		end
	end

	// Scan position; the shown channel keeps a cancelled channel.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_ch   <= FIRST_CH;
			shown_ch <= FIRST_CH;
		end else if (launch_scan) begin
			cur_ch   <= launch_ch;
			shown_ch <= launch_ch;
		end else if (launch_single && state == st_idle) begin
			shown_ch <= FIRST_CH;
		end
	end

	// ==========================================================
	// Core control pulses and settings.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_start_o   <= 1'b0;
			conv_abort_o   <= 1'b0;
			conv_channel_o <= FIRST_CH;
			conv_compare_o <= 1'b0;
			conv_double_o  <= 1'b0;
		end else begin
			conv_start_o <= launch_scan || launch_single;
			conv_abort_o <= abort;
			if (launch_single) begin
				conv_channel_o <= single_sel;
				conv_compare_o <= single_func;
				conv_double_o  <= single_rate;
			end else if (launch_scan) begin
				conv_channel_o <= launch_ch;
				conv_compare_o <= 1'b0;
				conv_double_o  <= scan_rate;
			end
		end
	end

	// Result transfer and end-of-pass requests.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_store_o   <= 1'b0;
			result_channel_o <= FIRST_CH;
			pass_irq_o       <= 1'b0;
			pass_dma_o       <= 1'b0;
		end else begin
			result_store_o   <= store;
			result_channel_o <= store_ch;
			pass_irq_o       <= pass_end && !scan_req;
			pass_dma_o       <= pass_end && scan_req;
		end
	end

	// ==========================================================
	// Checks.
	stop_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_cmd && state == st_scan |=> conv_abort_o && !conv_start_o
			&& state == st_idle && scan_done)
		else $error("scan stop did not abort");
	both_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_cmd && w_data_q[SC_START_BIT] && state == st_idle
			&& !single_go |=> state == st_idle && !conv_start_o)
		else $error("start with stop began a scan");
	single_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_cmd && state == st_single && !conv_done_i |=>
			state == st_single && !conv_abort_o && !queued)
		else $error("scan stop disturbed single");
	soft_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl && scan_kind && !hw_start && state == st_idle
			&& !single_go |=> !conv_start_o)
		else $error("start bit worked under hardware trigger");
	restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
		start_cmd && !stop_cmd && !single_go && state == st_scan |=>
			conv_abort_o && conv_start_o && conv_channel_o == FIRST_CH)
		else $error("scan restart missed");
	resume_a: assert property (@(posedge clk_i) disable iff (rst_i)
		single_go && state == st_scan && !stop_cmd |=> state == st_single
			&& queued && resume_ch == $past(cur_ch)
			&& conv_channel_o == $past(single_sel))
		else $error("single in scan did not save channel");
	done_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == st_scan || queued) |-> !scan_done)
		else $error("done flag high while scanning");
	oneshot_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state == st_scan && conv_done_i && sp.last && !scan_type
			&& !stop_cmd && !single_go && !scan_go |=>
			state == st_idle && scan_done && !conv_start_o)
		else $error("one-shot scan did not halt");
	pass_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state == st_scan && conv_done_i && sp.last && !stop_cmd
			&& !single_go && !scan_go |=>
			(pass_dma_o == $past(scan_req)) && (pass_irq_o != pass_dma_o))
		else $error("pass end request wrong");

endmodule : adc_scan_ctrl

// ---- adc_single_scan_mode_control_tb.sv ----
// Purpose: Self-checking bench for the converter control block.
// Assumes: The core model answers each start after eight cycles.
// Notes:   Registers are driven over AXI4-Lite by two tasks.
`timescale 1ns/1ps
module adc_single_scan_mode_control_tb;
	import adc_ctrl_pkg::*;
	logic clk_i = 0, rst_i = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic hw = 0, bv, rv, aw_r, w_r, ar_r, done, st, ab, cmp, dbl, sto;
	logic irq, dma;
	logic [31:0] aa = 0, wd = 0, ra = 0, rd, v;
	logic [1:0] bresp, rresp, rs;
	channel_t ch, rch;
	int n_errors = 0, check_count = 0, n_st, n_ab, n_irq, n_dma, n_sto;
	adc_scan_ctrl adc_scan_ctrl_i (.clk_i, .rst_i, .s_axi_awaddr_i(aa),
	 .s_axi_awvalid_i(awv), .s_axi_awready_o(aw_r), .s_axi_wdata_i(wd),
	 .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(w_r),
	 .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
	 .s_axi_araddr_i(ra), .s_axi_arvalid_i(arv), .s_axi_arready_o(ar_r),
	 .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
	 .s_axi_rready_i(rr), .hw_trigger_i(hw), .conv_done_i(done),
	 .conv_start_o(st), .conv_abort_o(ab), .conv_channel_o(ch),
	 .conv_compare_o(cmp), .conv_double_o(dbl), .result_store_o(sto),
	 .result_channel_o(rch), .pass_irq_o(irq), .pass_dma_o(dma));
	adc_core_model adc_core_model_i (.clk_i, .rst_i, .start_i(st),
	 .abort_i(ab), .done_o(done));
	// ==========================================================
	// Clock and pulse counters.
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n_st <= n_st + st;
		n_ab <= n_ab + ab;
		n_irq <= n_irq + irq;
		n_dma <= n_dma + dma;
		n_sto <= n_sto + sto;
	end
	task automatic clr;
		@(negedge clk_i); // Clear away from the counting edge.
		{n_st, n_ab, n_irq, n_dma, n_sto} = '0;
	endtask : clr
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic tmo(input bit hit);
		if (hit) begin
			n_errors++;
			close_out();
		end
	endtask : tmo
	// ==========================================================
	// Bus tasks hold each channel until its own ready is seen.
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		int i;
		bit ap = 1, wp = 1;
		@(posedge clk_i);
		aa <= a;
		wd <= {24'h0, d};
		awv <= 1;
		wv <= 1;
		br <= 1;
		for (i = 0; i < 99; i++) begin
			@(posedge clk_i);
			if (!ap && !wp && bv)
				break;
			if (ap && aw_r) begin
				ap = 0;
				awv <= 0;
			end
			if (wp && w_r) begin
				wp = 0;
				wv <= 0;
			end
		end
		br <= 0;
		tmo(i == 99);
		chk(bresp, RESP_OKAY);
	endtask : wr
	task automatic rd_reg(input logic [31:0] a);
		int i;
		bit p = 1;
		@(posedge clk_i);
		ra <= a;
		arv <= 1;
		rr <= 1;
		for (i = 0; i < 99; i++) begin
			@(posedge clk_i);
			if (!p && rv)
				break;
			if (p && ar_r) begin
				p = 0;
				arv <= 0;
			end
		end
		rr <= 0;
		v = rd;
		rs = rresp;
		tmo(i == 99);
	endtask : rd_reg
	task automatic wait_done;
		int i;
		for (i = 0; i < 60; i++) begin
			rd_reg(SCAN_CONTROL_ADDR);
			if (v[SC_DONE_BIT] === 1'b1)
				break;
		end
		tmo(i == 60);
	endtask : wait_done
	// ==========================================================
	// Scenarios.
	task automatic t_single;
		rd_reg(SCAN_CONTROL_ADDR);
		chk(v, 32'h04);
		rd_reg(32'h0080_0088);
		chk(rs, RESP_SLVERR);
		wr(SINGLE_CHANNEL_CONFIG_ADDR, 8'hc5);
		rd_reg(SINGLE_CHANNEL_CONFIG_ADDR);
		chk(v, 32'hc5);
		wr(SINGLE_COMMAND_ADDR, 8'h01);
		repeat (2) @(posedge clk_i);
		chk({ch, cmp, dbl}, 6'h17);
		repeat (12) @(posedge clk_i);
	endtask : t_single
	task automatic t_queue;
		wr(SCAN_CHANNEL_CONFIG_ADDR, 8'h04);
		wr(SINGLE_CHANNEL_CONFIG_ADDR, 8'h0a);
		clr();
		wr(SINGLE_COMMAND_ADDR, 8'h01);
		repeat (2) @(posedge clk_i);
		chk({ch, cmp, dbl}, 6'h28);
		wr(SCAN_CONTROL_ADDR, 8'h01);
		wait_done();
		chk(n_st, 5);
		chk(n_sto, 5);
		chk(n_irq, 1);
		chk(rch, 4'h3);
	endtask : t_queue
	task automatic t_cont;
		clr();
		wr(SCAN_CONTROL_ADDR, 8'h49);
		repeat (100) @(posedge clk_i);
		rd_reg(SCAN_CONTROL_ADDR);
		chk(v, 32'h48);
		wr(SCAN_CONTROL_ADDR, 8'h4a);
		@(posedge clk_i);
		chk(n_ab, 1);
		chk(n_dma > 1, 1);
		chk(n_irq, 0);
		rd_reg(SCAN_CONTROL_ADDR);
		chk(v, 32'h4c);
	endtask : t_cont
	task automatic t_trig;
		clr();
		wr(SCAN_CONTROL_ADDR, 8'h03);
		wr(SCAN_CONTROL_ADDR, 8'h30);
		wr(SCAN_CONTROL_ADDR, 8'h31);
		repeat (3) @(posedge clk_i);
		chk(n_st, 0);
		hw <= 1;
		@(posedge clk_i);
		hw <= 0;
		repeat (3) @(posedge clk_i);
		chk(n_st, 1);
		wr(SCAN_CONTROL_ADDR, 8'h32);
		rd_reg(SCAN_CONTROL_ADDR);
		chk(v, 32'h34);
	endtask : t_trig
	// Restart, single inside a scan, then a stop that spares the single.
	task automatic t_mix;
		wr(SCAN_CONTROL_ADDR, 8'h00);
		clr();
		wr(SCAN_CONTROL_ADDR, 8'h01);
		wr(SCAN_CONTROL_ADDR, 8'h01);
		chk({ch, st, ab}, 6'h03);
		wr(SINGLE_COMMAND_ADDR, 8'h01);
		chk({ch, st, ab}, 6'h2b);
		wr(SCAN_CONTROL_ADDR, 8'h02);
		chk({st, ab}, 2'h0);
		wait_done();
		chk(n_ab, 2);
		repeat (8) @(posedge clk_i);
		chk(n_sto, 1);
		chk(n_st, 3);
	endtask : t_mix
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		t_single();
		t_queue();
		t_cont();
		t_trig();
		t_mix();
		close_out();
	end
endmodule : adc_single_scan_mode_control_tb

// ---- scan_step.sv ----
// Purpose: Works out the next scan channel and the end of a pass.
// Assumes: Every pass starts at channel zero.
// Notes:   Loop codes 00 and 11 both give the full sixteen inputs.
`timescale 1ns/1ps
module scan_step (
	scan_step_if.step sp // Scan position exchange.
);
	import adc_ctrl_pkg::*;

	// ==========================================================
	// Pass length from the loop field.
	channel_t last_ch; // Highest channel of the pass.

	// The loop field alone sets the range, so a change takes effect
	// on the next step; a restart is the clean way to apply it.
	always_comb begin
		if (sp.loop == LOOP_4CH) begin
			last_ch = LAST_4CH;
		end else if (sp.loop == LOOP_8CH) begin
			last_ch = LAST_8CH;
		end else begin
			last_ch = LAST_16CH;
		end
	end

	// Wrap to the first channel after the last one.
	always_comb begin
		sp.last = (sp.cur >= last_ch);
		sp.next = sp.last ? FIRST_CH : channel_t'(sp.cur + 4'h1);
	end

endmodule : scan_step

// ---- scan_step_if.sv ----
// Purpose: Carries the scan position between controller and stepper.
// Assumes: Purely combinational exchange within one clock domain.
// Notes:   The controller owns loop and position, the stepper answers.
`timescale 1ns/1ps
interface scan_step_if;
	import adc_ctrl_pkg::*;
	logic [1:0] loop;     // Scan loop field as written.
	channel_t   cur;      // Channel now converted in the scan.
	channel_t   next;     // Channel that follows cur.
	logic       last;     // High when cur ends the pass.
	modport ctrl (output loop, output cur, input next, input last);
	modport step (input loop, input cur, output next, output last);
endinterface : scan_step_if
